// [scma_pkg.sv]
`default_nettype none
package scma_pkg;
	// ----------------------------------------
	// Memory layout
	// ----------------------------------------
	localparam int NV_BITS = 31;                    // Stored bits in total
	localparam int KEY_BITS = 22;                   // Security code bits
	localparam int SETUP_BITS = 9;                  // Configuration bits
	localparam logic [4:0] KEY_BIT_FIRST = 5'h00;   // Index of key_bit_first
	localparam logic [4:0] SETUP_BIT_FIRST = 5'h16; // Index of setup_bit_first
	localparam logic [4:0] SETUP_BIT_LAST = 5'h1e;  // Index of setup_bit_last
	// Contents after reset, value arbitrary
	localparam logic [30:0] NV_RESET = 31'h2d5a_3c96;
	// ----------------------------------------
	// Counts
	// ----------------------------------------
	localparam logic [2:0] POR_CYCLES = 3'h4; // Power-on reset length
	localparam logic [2:0] RST_PULSES = 3'h4; // Reset pulses per operation
	localparam logic [5:0] DATA_PULSES = 6'h1f; // Data pulses per word
	localparam logic [5:0] DATA_SAT = 6'h3f;  // Data count saturation
	localparam int FIFO_DEPTH = 4;            // Word FIFO depth
	// ----------------------------------------
	// Mode pin codes and APB map
	// ----------------------------------------
	localparam logic [1:0] FORCE_READ = 2'h1; // Read forcing level
	localparam logic [1:0] FORCE_PROG = 2'h2; // Program forcing level
	localparam logic [7:0] REG_CTRL = 8'h00;   // Control
	localparam logic [7:0] REG_STATUS = 8'h04; // Status, sticky bits W1C
	localparam logic [7:0] REG_STORE = 8'h08;  // Stored word
	localparam logic [7:0] REG_SETUP = 8'h0c;  // Loaded configuration
	localparam logic [7:0] REG_FIFO = 8'h10;   // Word FIFO pop
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001; // Capture enabled
	localparam int STS_OK = 11;   // Commit done clear bit position, flag reads at bit 13
	localparam int STS_FAIL = 12; // Commit refused clear bit position, flag reads at bit 14
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {ST_POR, ST_NORMAL, ST_READ, ST_PROG} scma_state_e;
	typedef struct packed {
		logic level; // Synchronised level
		logic rise;  // Rising edge pulse
		logic fall;  // Falling edge pulse
	} scma_edge_s;
endpackage : scma_pkg
`default_nettype wire

// [scma_pin_sync.sv]
`default_nettype none
// ----------------------------------------
// Two-flop synchroniser with edge detect
// ----------------------------------------
module scma_pin_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,    // System clock
	input  wire logic         presetn, // Async reset, low
	input  wire logic [W-1:0] pin_in,  // Raw pins
	output logic      [W-1:0] level,   // Synchronised levels
	output logic      [W-1:0] rise,    // Rising edges
	output logic      [W-1:0] fall     // Falling edges
);
	logic [W-1:0] meta; // First stage, read only by level
	logic [W-1:0] prev; // Delayed level for edges

	// Shift chain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= '0;
			level <= '0;
			prev <= '0;
		end else begin
			meta <= pin_in;
			level <= meta;
			prev <= level;
		end
	end

	assign rise = level & ~prev;
	assign fall = ~level & prev;
endmodule : scma_pin_sync
`default_nettype wire

// [scma_fifo.sv]
`default_nettype none
// ----------------------------------------
// Small flop FIFO, valid/ready both sides
// ----------------------------------------
module scma_fifo #(
	parameter int W = 31,
	parameter int D = 4
) (
	input  wire logic         pclk,      // System clock
	input  wire logic         presetn,   // Async reset, low
	input  wire logic         in_valid,  // Word offered
	output logic              in_ready,  // Room for a word
	input  wire logic [W-1:0] in_data,   // Word in
	output logic              out_valid, // Word held
	input  wire logic         out_ready, // Word taken
	output logic      [W-1:0] out_data   // Head word
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];   // Storage
	logic [AW:0]  wr_ptr;    // Write pointer, wrap bit on top
	logic [AW:0]  rd_ptr;    // Read pointer, wrap bit on top
	wire          push = in_valid & in_ready;
	wire          pop = out_valid & out_ready;

	assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data = mem[rd_ptr[AW-1:0]];

	// Pointers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
			if (pop) rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
		end
	end

	// Storage write
	always_ff @(posedge pclk) begin
		if (push) mem[wr_ptr[AW-1:0]] <= in_data;
	end
endmodule : scma_fifo
`default_nettype wire

// [scma_core.sv]
`default_nettype none
module scma_core
	import scma_pkg::*;
(
	input  wire logic        pclk,              // System clock, 125 MHz
	input  wire logic        presetn,           // Async reset, low
	input  wire logic        psel,              // APB select
	input  wire logic        penable,           // APB enable
	input  wire logic        pwrite,            // APB direction
	input  wire logic [7:0]  paddr,             // APB byte address
	input  wire logic [31:0] pwdata,            // APB write data
	output logic      [31:0] prdata,            // APB read data
	output logic             pready,            // APB ready
	output logic             pslverr,           // APB error
	input  wire logic        serial_strobe_pin, // Strobe from programmer
	input  wire logic [1:0]  mode_force_pin,    // Read or program forcing level
	input  wire logic        commit_pin,        // Commit pulse
	input  wire logic        data_in_pin,       // Serial data in
	output logic             data_out_pin,      // Serial data out
	output logic [8:0]       setup_cfg          // Loaded configuration bits
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	scma_state_e  state;       // Operating state
	scma_state_e  next_state;  // State after this edge
	logic [2:0]   por_cnt;     // Power-on reset cycle count
	logic [2:0]   rst_cnt;     // Reset pulses seen
	logic [5:0]   data_cnt;    // Data pulses seen, saturating
	logic [4:0]   bit_idx;     // Bit position in the word
	logic [30:0]  nv;          // Stored word
	logic [30:0]  shadow;      // Captured word
	logic         cap_en;      // Push words to FIFO
	logic         push_pend;   // Word waiting for FIFO room
	logic         commit_req;  // Accepted commit waiting
	logic         commit_ok;   // Sticky, commit done
	logic         commit_fail; // Sticky, commit refused
	logic [4:0]   pin_lvl;     // Synchronised pins
	logic [4:0]   pin_rise;    // Pin rising edges
	logic [4:0]   pin_fall;    // Pin falling edges
	scma_edge_s   strobe;      // Strobe events
	scma_edge_s   commit;      // Commit events
	logic         fifo_ready;  // FIFO has room
	logic         fifo_valid;  // FIFO holds a word
	logic [30:0]  fifo_head;   // FIFO head word
	logic         pop_go;      // FIFO pop on a bus read

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	scma_pin_sync #(.W(5)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pin_in  ({mode_force_pin, commit_pin, data_in_pin, serial_strobe_pin}),
		.level   (pin_lvl),
		.rise    (pin_rise),
		.fall    (pin_fall)
	);

	// Named views of the synchronised pins
	assign strobe = '{level: pin_lvl[0], rise: pin_rise[0], fall: pin_fall[0]};
	assign commit = '{level: pin_lvl[2], rise: pin_rise[2], fall: pin_fall[2]};
	wire       data_lvl = pin_lvl[1];
	wire [1:0] force_lvl = pin_lvl[4:3];

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	wire por_end = (state == ST_POR) && (por_cnt == POR_CYCLES - 3'h1);
	wire [1:0] mode_sel = (force_lvl == FORCE_READ) ? 2'(ST_READ) :
		(force_lvl == FORCE_PROG) ? 2'(ST_PROG) : 2'(ST_NORMAL);
	wire op_entry = (next_state != state) && (next_state inside {ST_READ, ST_PROG});
	wire in_op = (state == ST_READ) || (state == ST_PROG);
	wire rst_phase = rst_cnt < RST_PULSES;
	wire reset_fall = in_op && strobe.fall && rst_phase;
	wire data_fall = in_op && strobe.fall && !rst_phase;
	wire data_rise = in_op && strobe.rise && !rst_phase;
	wire last_bit = bit_idx == SETUP_BIT_LAST;
	wire nxt_bit = last_bit ? 1'b0 : nv[bit_idx + 5'h01];
	wire word_done = data_fall && last_bit;
	wire counts_ok = (rst_cnt == RST_PULSES) && (data_cnt == DATA_PULSES);
	wire commit_go = commit_req && !push_pend && counts_ok && (state == ST_PROG);

	// Next state
	always_comb begin
		next_state = state;
		unique case (state)
			ST_POR: if (por_end) next_state = scma_state_e'(mode_sel);
			ST_NORMAL, ST_READ, ST_PROG: next_state = scma_state_e'(mode_sel);
		endcase
	end

	// ----------------------------------------
	// Power-on reset and state
	// ----------------------------------------
	// four clock periods
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_POR;
			por_cnt <= '0;
		end else begin
			state <= next_state;
			if (state == ST_POR) por_cnt <= por_cnt + 3'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) setup_cfg <= '0;
		else if (por_end) setup_cfg <= nv[SETUP_BIT_LAST:SETUP_BIT_FIRST];
	end

	// ----------------------------------------
	// Pulse counters
	// ----------------------------------------
	// restart counts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_cnt <= '0;
			data_cnt <= '0;
			bit_idx <= '0;
		end else if (op_entry) begin
			rst_cnt <= '0;
			data_cnt <= '0;
			bit_idx <= '0;
		end else begin
			if (reset_fall) rst_cnt <= rst_cnt + 3'h1;
			if (data_fall && data_cnt != DATA_SAT) data_cnt <= data_cnt + 6'h01;
			if (data_fall) bit_idx <= last_bit ? 5'h00 : bit_idx + 5'h01;
		end
	end

	// ----------------------------------------
	// Serial output
	// ----------------------------------------
	// first bit on rise, rest on falls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) data_out_pin <= 1'b0;
		else if (!in_op) data_out_pin <= 1'b0;
		else if (data_rise && bit_idx == KEY_BIT_FIRST) data_out_pin <= nv[KEY_BIT_FIRST];
		else if (data_fall) data_out_pin <= nxt_bit;
	end

	// ----------------------------------------
	// Capture and commit
	// ----------------------------------------
	// Pulses past the 31st write nothing
	// capture on strobe fall
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) shadow <= '0;
		else if (state == ST_PROG && data_fall && data_cnt < DATA_PULSES) shadow[bit_idx] <= data_lvl;
	end

	// Commit request held until FIFO takes the word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) commit_req <= 1'b0;
		else if (state != ST_PROG || commit_go) commit_req <= 1'b0;
		else if (commit.rise && counts_ok) commit_req <= 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) nv <= NV_RESET;
		else if (commit_go) nv <= shadow;
	end

	// FIFO push pending
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) push_pend <= 1'b0;
		else if (word_done && cap_en) push_pend <= 1'b1;
		else if (fifo_ready) push_pend <= 1'b0;
	end

	scma_fifo #(.W(NV_BITS), .D(FIFO_DEPTH)) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (push_pend),
		.in_ready  (fifo_ready),
		.in_data   ((state == ST_PROG) ? shadow : nv),
		.out_valid (fifo_valid),
		.out_ready (pop_go),
		.out_data  (fifo_head)
	);

	// ----------------------------------------
	// APB slave, one wait state
	// ----------------------------------------
	// Address decode and strobes
	wire acc = psel && penable;
	wire done = acc && pready;
	wire hit_ctrl = paddr == REG_CTRL;
	wire hit_sts = paddr == REG_STATUS;
	wire hit_any = hit_ctrl || hit_sts || paddr == REG_STORE || paddr == REG_SETUP || paddr == REG_FIFO;
	assign pop_go = done && !pwrite && paddr == REG_FIFO;
	wire clr_go = done && pwrite && hit_sts;
	// Status word, sticky flags on top
	wire [31:0] sts_word = {17'h0, commit_fail, commit_ok, fifo_valid, !fifo_ready,
		data_cnt, rst_cnt, 2'(state)};
	// Read data select
	wire [31:0] rd_mux = hit_ctrl ? {31'h0, cap_en} : hit_sts ? sts_word :
		(paddr == REG_STORE) ? {1'b0, nv} : (paddr == REG_SETUP) ? {23'h0, setup_cfg} :
		(paddr == REG_FIFO) ? {fifo_valid, fifo_head} : 32'h0;

	// Handshake and read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= acc && !pready;
			pslverr <= acc && !pready && !hit_any;
			if (acc && !pready) prdata <= pwrite ? 32'h0 : rd_mux;
		end
	end

	// Control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) cap_en <= CTRL_RESET[0];
		else if (done && pwrite && hit_ctrl) cap_en <= pwdata[0];
	end

	// Sticky flags, set beats clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			commit_ok <= 1'b0;
			commit_fail <= 1'b0;
		end else begin
			commit_ok <= commit_go || (commit_ok && !(clr_go && pwdata[STS_OK]));
			commit_fail <= (state == ST_PROG && commit.rise && !counts_ok) ||
				(commit_fail && !(clr_go && pwdata[STS_FAIL]));
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Sequences for multi-step checks
	sequence s_por_leave;
		$past(state) == ST_POR && state != ST_POR;
	endsequence
	sequence s_last_fall;
		data_fall && bit_idx == SETUP_BIT_LAST;
	endsequence

	por_length_a: assert property (s_por_leave |-> $past(por_cnt) == 3'h3)
		else $error("power-on reset not four cycles");
	setup_load_a: assert property (s_por_leave |-> setup_cfg == $past(nv[30:22]))
		else $error("setup bits not loaded");
	store_guard_a: assert property (!commit_go |=> nv == $past(nv))
		else $error("store changed without commit");
	out_change_a: assert property ($changed(data_out_pin) && in_op && $past(in_op)
		|-> $past(data_fall) || $past(data_rise))
		else $error("output moved off a strobe edge");
	out_bit_a: assert property (data_fall && !op_entry |=> data_out_pin == $past(nxt_bit))
		else $error("wrong bit shifted out");
	readout_wrap_a: assert property ((s_last_fall and !op_entry) |=> bit_idx == 5'h00)
		else $error("readout did not restart");
	capture_bit_a: assert property (state == ST_PROG && data_fall && data_cnt < 6'h1f && !op_entry
		|=> shadow[$past(bit_idx)] == $past(data_lvl))
		else $error("data bit not captured");
	prog_out_a: assert property (state == ST_PROG && data_fall && !op_entry
		|=> data_out_pin == $past(nxt_bit))
		else $error("program mode output not stored data");
	commit_count_a: assert property (nv != $past(nv) |-> $past(rst_cnt) == 3'h4
		&& $past(data_cnt) == 6'h1f)
		else $error("commit with wrong pulse counts");
	entry_clear_a: assert property (op_entry |=> rst_cnt == 3'h0 && data_cnt == 6'h00)
		else $error("counters not cleared on entry");

	// Output, setup and flag checks
	setup_hold_a: assert property ($past(state) != ST_POR |-> $stable(setup_cfg))
		else $error("setup bits changed after load");
	first_bit_a: assert property (data_rise && bit_idx == KEY_BIT_FIRST |=> data_out_pin == $past(nv[KEY_BIT_FIRST]))
		else $error("first key bit not shown on rise");
	out_idle_a: assert property (!in_op |=> !data_out_pin)
		else $error("output not low outside read or program");
	ok_sticky_a: assert property (commit_go |=> commit_ok)
		else $error("commit done flag not set");
endmodule : scma_core
`default_nettype wire

// [scma_prog_model.sv]
`default_nettype none
// ----------------------------------------
// External programmer driving strobe and data
// ----------------------------------------
module scma_prog_model
	import scma_pkg::*;
#(
	parameter int SETTLE_CYC = 20, // Mode settle wait, shortened
	parameter int HALF_CYC   = 10  // Strobe half period, 160 ns total
) (
	input  wire logic  pclk,              // System clock
	input  wire logic  data_out_pin,      // Serial data from device
	output logic       serial_strobe_pin, // Strobe to device
	output logic [1:0] mode_force_pin,    // Mode forcing level
	output logic       commit_pin,        // Commit pulse
	output logic       data_in_pin        // Serial data to device
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle levels, strobe stands still between frames
	initial begin
		serial_strobe_pin = 1'b0;
		mode_force_pin    = 2'h0;
		commit_pin        = 1'b0;
		data_in_pin       = 1'b0;
	end

	task automatic enter(input logic [1:0] m);
		@(posedge pclk);
		mode_force_pin <= m;
		repeat (SETTLE_CYC) @(posedge pclk);
	endtask : enter

	// Back to normal mode
	task automatic leave();
		enter(2'h0);
	endtask : leave

	// One strobe pulse, output sampled late in high phase
	task automatic pulse(input logic d, output logic seen);
		@(posedge pclk);
		serial_strobe_pin <= 1'b1;
		data_in_pin       <= d;
		repeat (HALF_CYC) @(posedge pclk);
		seen = data_out_pin;
		serial_strobe_pin <= 1'b0;
		repeat (HALF_CYC / 2) @(posedge pclk);
		// Hold time over, data no longer valid
		data_in_pin <= ~d;
		repeat (HALF_CYC / 2 - 1) @(posedge pclk);
	endtask : pulse

	task automatic resets(input int n);
		logic s;
		repeat (n) pulse(1'b0, s);
	endtask : resets

	task automatic word(input int n, input logic [30:0] w, output logic [30:0] seen);
		logic s;
		seen = 31'h0;
		for (int k = 0; k < n; k++) begin
			pulse((k < 31) ? w[k] : 1'b0, s);
			if (k < 31) seen[k] = s;
		end
	endtask : word

	task automatic commit();
		repeat (2 * HALF_CYC) @(posedge pclk);
		commit_pin <= 1'b1;
		repeat (HALF_CYC) @(posedge pclk);
		commit_pin <= 1'b0;
		repeat (2 * HALF_CYC) @(posedge pclk);
	endtask : commit
endmodule : scma_prog_model
`default_nettype wire

// [scma_core_bench.sv]
`default_nettype none
module scma_core_bench
	import scma_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr; // Bus and clock
	logic [7:0]  paddr;     // Byte address
	logic [31:0] pwdata;    // Write data
	logic [31:0] prdata;    // Read data
	logic        strobe, commit, din, dout; // Serial pins
	logic [1:0]  mode;      // Mode forcing level
	logic [8:0]  setup_cfg; // Loaded configuration
	logic [31:0] rd;        // Last read value
	logic        err;       // Last error flag
	logic [30:0] seen;      // Bits seen on serial out
	int          failures, cmp_count;
	int          rst_n [4] = '{4, 4, 3, 5};    // Reset counts, bad in the last two
	int          dat_n [4] = '{30, 32, 31, 31}; // Data counts, bad in the first two
	localparam logic [30:0] NEW_WORD = 31'h1a3c_c3a5; // Programmed word
	// ----------------------------------------
	// Instances
	// ----------------------------------------
	scma_core u_scma_core (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_strobe_pin(strobe), .mode_force_pin(mode), .commit_pin(commit),
		.data_in_pin(din), .data_out_pin(dout), .setup_cfg(setup_cfg)
	);
	scma_prog_model u_scma_prog_model (
		.pclk(pclk), .data_out_pin(dout), .serial_strobe_pin(strobe),
		.mode_force_pin(mode), .commit_pin(commit), .data_in_pin(din)
	);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	// Counts and verdict, ends the run
	task automatic test_done();
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : test_done

	// Compare seen against expected
	task automatic chk(input string name, input logic [31:0] sv, input logic [31:0] ev);
		cmp_count++;
		if (sv !== ev) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, ev, sv);
		end
	endtask : chk

	// One bus transfer, waits for pready under a bound
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			failures++;
			test_done();
		end
	endtask : apb
	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	initial begin
		repeat (100000) @(posedge pclk);
		failures++;
		test_done();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		failures  = 0;
		cmp_count = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("setup_early", {23'h0, setup_cfg}, 32'h0);
		repeat (2) @(posedge pclk);
		chk("setup_cfg", {23'h0, setup_cfg}, {23'h0, NV_RESET[30:22]});
		$display("test power_on done");
		apb(1'b0, REG_STORE, 32'h0);
		chk("store", rd, {1'b0, NV_RESET});
		apb(1'b0, REG_SETUP, 32'h0);
		chk("setup_reg", rd, {23'h0, NV_RESET[30:22]});
		apb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl", rd, CTRL_RESET);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("state", {21'h0, rd[10:0]}, 32'h1);
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
		$display("test registers done");
		// Read mode, four groups fill the buffer
		u_scma_prog_model.enter(FORCE_READ);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("read_entry", {21'h0, rd[10:0]}, 32'h2);
		u_scma_prog_model.resets(4);
		for (int g = 0; g < 4; g++) begin
			u_scma_prog_model.word(31, 31'h0, seen);
			chk("readout", {1'b0, seen}, {1'b0, NV_RESET});
		end
		u_scma_prog_model.leave();
		for (int g = 0; g < 4; g++) begin
			apb(1'b0, REG_FIFO, 32'h0);
			chk("fifo_word", rd, {1'b1, NV_RESET});
		end
		apb(1'b0, REG_FIFO, 32'h0);
		chk("fifo_empty", {31'h0, rd[31]}, 32'h0);
		$display("test read done");
		// Program a new word and commit it
		u_scma_prog_model.enter(FORCE_PROG);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("prog_entry", {21'h0, rd[10:0]}, 32'h3);
		u_scma_prog_model.resets(4);
		u_scma_prog_model.word(31, NEW_WORD, seen);
		chk("old_out", {1'b0, seen}, {1'b0, NV_RESET});
		u_scma_prog_model.commit();
		u_scma_prog_model.leave();
		apb(1'b0, REG_STORE, 32'h0);
		chk("committed", rd, {1'b0, NEW_WORD});
		apb(1'b0, REG_FIFO, 32'h0);
		chk("prog_word", rd, {1'b1, NEW_WORD});
		apb(1'b0, REG_STATUS, 32'h0);
		chk("commit_ok", {30'h0, rd[14:13]}, 32'h1);
		apb(1'b1, REG_CTRL, 32'h0);
		$display("test program done");
		// Wrong pulse counts are refused
		for (int i = 0; i < 4; i++) begin
			u_scma_prog_model.enter(FORCE_PROG);
			u_scma_prog_model.resets(rst_n[i]);
			u_scma_prog_model.word(dat_n[i], ~NEW_WORD, seen);
			u_scma_prog_model.commit();
			u_scma_prog_model.leave();
			apb(1'b0, REG_STORE, 32'h0);
			chk("refused", rd, {1'b0, NEW_WORD});
		end
		apb(1'b0, REG_STATUS, 32'h0);
		chk("commit_fail", {29'h0, rd[14:12]}, 32'h6);
		apb(1'b1, REG_STATUS, (32'h1 << STS_OK) | (32'h1 << STS_FAIL));
		apb(1'b0, REG_STATUS, 32'h0);
		chk("flags_clear", {29'h0, rd[14:12]}, 32'h0);
		u_scma_prog_model.enter(FORCE_READ);
		u_scma_prog_model.resets(4);
		u_scma_prog_model.word(31, 31'h0, seen);
		chk("new_readout", {1'b0, seen}, {1'b0, NEW_WORD});
		u_scma_prog_model.leave();
		$display("test refusal done");
		test_done();
	end
endmodule : scma_core_bench
`default_nettype wire
